// >>> core/radio_test_status_map.svh
// Register indices, field positions, reset values and state codes of the status bank
`ifndef RADIO_TEST_STATUS_MAP_SVH
`define RADIO_TEST_STATUS_MAP_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_CFG_A          6'h2D
`define IDX_CFG_B          6'h2E
`define IDX_PART           6'h30
`define IDX_REVISION       6'h31
`define IDX_OFFSET_EST     6'h32
`define IDX_CHECKSUM       6'h33
`define IDX_STRENGTH       6'h34
`define IDX_CTRL_STATE     6'h35
`define IDX_IRQ_STATUS     6'h38
`define IDX_IRQ_MASK       6'h39

// ----------------------------------------------------------------
// Reset and forced values
// ----------------------------------------------------------------
`define RST_CFG_A          8'h31
`define WAKE_CFG_A_HOLD    8'h35
`define RST_CFG_B          8'h0B
`define RST_IRQ_MASK       4'h0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_OSC_SEL_CAL    1
`define BIT_CRC_MATCH      7
`define IRQ_CRC_MATCH      0
`define IRQ_RX_OVERFLOW    1
`define IRQ_TX_UNDERFLOW   2
`define IRQ_WAKE           3
`define IRQ_WIDTH          4

// ----------------------------------------------------------------
// Radio control state codes
// ----------------------------------------------------------------
`define ST_SLEEP           5'h00
`define ST_IDLE            5'h01
`define ST_CRYSTAL_OFF     5'h02
`define ST_RX_OVERFLOW     5'h11
`define ST_TX_UNDERFLOW    5'h16

`endif

// >>> core/radio_test_status_pkg.sv
// Types shared by the radio test and status register bank
package radio_test_status_pkg;

  // ----------------------------------------------------------------
  // Status values produced by the radio datapath
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] ctrl_state;
    logic [7:0] offset_est;
    logic       ook_mode;
    logic [7:0] strength;
    logic       crc_done;
    logic       crc_match;
    logic       rx_enter;
    logic       wake;
    logic       hold_select;
  } radio_status_t;

  // ----------------------------------------------------------------
  // Analog configuration handed to the radio
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cfg_a;
    logic [7:0] cfg_b;
    logic       osc_select_cal_enable;
  } analog_cfg_t;

endpackage : radio_test_status_pkg

// >>> core/radio_test_status_regs.sv
// Wishbone register bank for analog test settings and radio status
//
// The implementer's own choice: register access over Wishbone.
`include "radio_test_status_map.svh"

module radio_test_status_regs
  import radio_test_status_pkg::*;
#(
  parameter logic [7:0] PART_CODE     = 8'h5A,  // Arbitrary value
  parameter logic [7:0] REVISION_CODE = 8'h13   // Arbitrary value
) (
  input  wire logic          CORE_CLK_I,
  input  wire logic          RESETN_I,
  input  wire logic          WB_CYC_I,
  input  wire logic          WB_STB_I,
  input  wire logic          WB_WE_I,
  input  wire logic [7:0]    WB_ADR_I,
  input  wire logic [3:0]    WB_SEL_I,
  input  wire logic [31:0]   WB_DAT_I,
  output logic      [31:0]   WB_DAT_O,
  output logic               WB_ACK_O,
  input  wire radio_status_t RADIO_STATUS_I,
  input  wire logic          CHIP_SELECT_LOW_N_I,
  output logic               WAKE_TO_IDLE_O,
  output analog_cfg_t        ANALOG_CFG_O,
  output logic               IRQ_O
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_dormant(input logic [4:0] code);
    is_dormant = (code == `ST_SLEEP) || (code == `ST_CRYSTAL_OFF);
  endfunction : is_dormant

  function automatic logic [31:0] byte_word(input logic [7:0] b);
    byte_word = {24'h00_0000, b};
  endfunction : byte_word

  // ----------------------------------------------------------------
  // Chip select synchroniser
  // ----------------------------------------------------------------
  logic cs_meta_q;
  logic cs_sync_q;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
    end else begin
      cs_meta_q <= CHIP_SELECT_LOW_N_I;
      cs_sync_q <= cs_meta_q;
    end
  end

  wire cs_active = !cs_sync_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        ack_q;
  logic [31:0] dat_q;

  wire [5:0] index     = WB_ADR_I[7:2];
  wire       req       = WB_CYC_I && WB_STB_I;
  wire       commit    = req && ack_q;
  wire       wr_commit = commit && WB_WE_I && WB_SEL_I[0];
  wire       rd_commit = commit && !WB_WE_I;

  // Only writable registers decode a write strobe
  wire wr_cfg_a = wr_commit && (index == `IDX_CFG_A);
  wire wr_cfg_b = wr_commit && (index == `IDX_CFG_B);
  wire wr_mask  = wr_commit && (index == `IDX_IRQ_MASK);
  wire rd_irq   = rd_commit && (index == `IDX_IRQ_STATUS);

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  // ----------------------------------------------------------------
  // Analog test configuration
  // ----------------------------------------------------------------
  logic [7:0] cfg_a_q;
  logic [7:0] cfg_a_d;
  logic [7:0] analog_a_q;
  logic [7:0] analog_a_d;
  logic [7:0] cfg_b_q;
  logic [7:0] cfg_b_d;

  wire        wake     = RADIO_STATUS_I.wake;
  wire [7:0]  wake_val = RADIO_STATUS_I.hold_select ? `WAKE_CFG_A_HOLD : `RST_CFG_A;

  // Wake forcing wins over a write landing in the same cycle
  assign analog_a_d = wake     ? wake_val         :
                      wr_cfg_a ? WB_DAT_I[7:0]    :
                                 analog_a_q;

  // Host-visible copy hides the retention inversion
  assign cfg_a_d    = wake     ? `RST_CFG_A       :
                      wr_cfg_a ? WB_DAT_I[7:0]    :
                                 cfg_a_q;

  assign cfg_b_d    = wr_cfg_b ? WB_DAT_I[7:0] : cfg_b_q;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      cfg_a_q    <= `RST_CFG_A;
      analog_a_q <= `RST_CFG_A;
      cfg_b_q    <= `RST_CFG_B;
    end else begin
      cfg_a_q    <= cfg_a_d;
      analog_a_q <= analog_a_d;
      cfg_b_q    <= cfg_b_d;
    end
  end

  // ----------------------------------------------------------------
  // Checksum result flag
  // ----------------------------------------------------------------
  logic crc_ok_q;
  logic crc_ok_d;

  wire crc_good = RADIO_STATUS_I.crc_done && RADIO_STATUS_I.crc_match;
  wire crc_bad  = RADIO_STATUS_I.crc_done && !RADIO_STATUS_I.crc_match;

  // A match in the same cycle as a receive restart is kept
  assign crc_ok_d = crc_good                              ? 1'b1 :
                    (RADIO_STATUS_I.rx_enter || crc_bad)  ? 1'b0 :
                                                            crc_ok_q;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      crc_ok_q <= 1'b0;
    end else begin
      crc_ok_q <= crc_ok_d;
    end
  end

  // ----------------------------------------------------------------
  // Radio control state reporting
  // ----------------------------------------------------------------
  logic [4:0] state_prev_q;

  wire [4:0] raw_state = RADIO_STATUS_I.ctrl_state;

  // A read implies chip select, which has already woken the radio
  wire [4:0] shown_state = is_dormant(raw_state) ? `ST_IDLE : raw_state;

  wire enter_overflow  = (raw_state == `ST_RX_OVERFLOW)
                      && (state_prev_q != `ST_RX_OVERFLOW);
  wire enter_underflow = (raw_state == `ST_TX_UNDERFLOW)
                      && (state_prev_q != `ST_TX_UNDERFLOW);

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      state_prev_q <= `ST_SLEEP;
    end else begin
      state_prev_q <= raw_state;
    end
  end

  // Request to leave sleep or crystal-off while selected
  logic wake_req_q;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      wake_req_q <= 1'b0;
    end else begin
      wake_req_q <= cs_active && is_dormant(raw_state);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  logic [`IRQ_WIDTH-1:0] irq_status_q;
  logic [`IRQ_WIDTH-1:0] irq_status_d;
  logic [`IRQ_WIDTH-1:0] irq_mask_q;
  logic [`IRQ_WIDTH-1:0] irq_mask_d;
  logic [`IRQ_WIDTH-1:0] irq_events;
  logic [`IRQ_WIDTH-1:0] irq_clear;
  logic                  irq_q;

  always_comb begin
    irq_events                    = '0;
    irq_events[`IRQ_CRC_MATCH]    = crc_good;
    irq_events[`IRQ_RX_OVERFLOW]  = enter_overflow;
    irq_events[`IRQ_TX_UNDERFLOW] = enter_underflow;
    irq_events[`IRQ_WAKE]         = wake;
  end

  // Clear only what the read returned, so later events survive
  assign irq_clear    = rd_irq ? dat_q[`IRQ_WIDTH-1:0] : '0;
  assign irq_status_d = (irq_status_q & ~irq_clear) | irq_events;
  assign irq_mask_d   = wr_mask ? WB_DAT_I[`IRQ_WIDTH-1:0] : irq_mask_q;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      irq_status_q <= '0;
      irq_mask_q   <= `RST_IRQ_MASK;
      irq_q        <= 1'b0;
    end else begin
      irq_status_q <= irq_status_d;
      irq_mask_q   <= irq_mask_d;
      irq_q        <= |(irq_status_d & irq_mask_d);
    end
  end

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  logic [31:0] rd_data;

  wire [7:0] offset_shown = RADIO_STATUS_I.ook_mode ? 8'h00 :
                            RADIO_STATUS_I.offset_est;
  wire [7:0] crc_byte     = {crc_ok_q, 7'h00};
  wire [7:0] state_byte   = {3'h0, shown_state};

  always_comb begin
    unique case (index)
      `IDX_CFG_A:      rd_data = byte_word(cfg_a_q);
      `IDX_CFG_B:      rd_data = byte_word(cfg_b_q);
      `IDX_PART:       rd_data = byte_word(PART_CODE);
      `IDX_REVISION:   rd_data = byte_word(REVISION_CODE);
      `IDX_OFFSET_EST: rd_data = byte_word(offset_shown);
      `IDX_CHECKSUM:   rd_data = byte_word(crc_byte);
      `IDX_STRENGTH:   rd_data = byte_word(RADIO_STATUS_I.strength);
      `IDX_CTRL_STATE: rd_data = byte_word(state_byte);
      `IDX_IRQ_STATUS: rd_data = {28'h000_0000, irq_status_q};
      `IDX_IRQ_MASK:   rd_data = {28'h000_0000, irq_mask_q};
      default:         rd_data = 32'h0000_0000;
    endcase
  end

  // Data is captured with the acknowledge and held while it stands
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      dat_q <= 32'h0000_0000;
    end else if (req && !ack_q) begin
      dat_q <= WB_WE_I ? 32'h0000_0000 : rd_data;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic osc_sel_q;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      osc_sel_q <= 1'b1;
    end else begin
      osc_sel_q <= cfg_b_d[`BIT_OSC_SEL_CAL];
    end
  end

  assign WB_ACK_O                           = ack_q;
  assign WB_DAT_O                           = dat_q;
  assign IRQ_O                              = irq_q;
  assign WAKE_TO_IDLE_O                     = wake_req_q;
  assign ANALOG_CFG_O.cfg_a                 = analog_a_q;
  assign ANALOG_CFG_O.cfg_b                 = cfg_b_q;
  assign ANALOG_CFG_O.osc_select_cal_enable = osc_sel_q;

endmodule : radio_test_status_regs

// >>> testbench/radio_test_status_properties.sv
// Port-level assertions for the radio test and status register bank
`include "radio_test_status_map.svh"
module radio_test_status_properties
  import radio_test_status_pkg::*;
#(
  parameter logic [7:0] PART_CODE     = 8'h5A,
  parameter logic [7:0] REVISION_CODE = 8'h13
) (
  input wire logic          CORE_CLK_I,
  input wire logic          RESETN_I,
  input wire logic          WB_CYC_I,
  input wire logic          WB_STB_I,
  input wire logic          WB_WE_I,
  input wire logic [7:0]    WB_ADR_I,
  input wire logic [31:0]   WB_DAT_O,
  input wire logic          WB_ACK_O,
  input wire radio_status_t RADIO_STATUS_I,
  input wire logic          CHIP_SELECT_LOW_N_I,
  input wire logic          WAKE_TO_IDLE_O,
  input wire analog_cfg_t   ANALOG_CFG_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESETN_I);
  wire logic       rd_ack = WB_ACK_O && !WB_WE_I;
  wire logic [5:0] idx    = WB_ADR_I[7:2];
  wire logic [4:0] st     = RADIO_STATUS_I.ctrl_state;
  sequence s_taken; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
  sequence s_answer; WB_ACK_O ##1 !WB_ACK_O; endsequence
  property p_ack; s_taken |=> s_answer; endproperty
  property p_part; rd_ack && idx == `IDX_PART |-> WB_DAT_O == 32'(PART_CODE); endproperty
  property p_rev; rd_ack && idx == `IDX_REVISION |-> WB_DAT_O == 32'(REVISION_CODE); endproperty
  property p_offset;
    rd_ack && idx == `IDX_OFFSET_EST |-> WB_DAT_O ==
      32'($past(RADIO_STATUS_I.ook_mode) ? 8'h00 : $past(RADIO_STATUS_I.offset_est));
  endproperty
  property p_state;
    rd_ack && idx == `IDX_CTRL_STATE |-> WB_DAT_O ==
      32'(($past(st) == `ST_SLEEP || $past(st) == `ST_CRYSTAL_OFF) ? `ST_IDLE : $past(st));
  endproperty
  property p_crc; rd_ack && idx == `IDX_CHECKSUM |-> WB_DAT_O[6:0] == 7'h00; endproperty
  property p_osc;
    ANALOG_CFG_O.osc_select_cal_enable == ANALOG_CFG_O.cfg_b[`BIT_OSC_SEL_CAL];
  endproperty
  property p_wake;
    RADIO_STATUS_I.wake |=> ANALOG_CFG_O.cfg_a ==
      ($past(RADIO_STATUS_I.hold_select) ? `WAKE_CFG_A_HOLD : `RST_CFG_A);
  endproperty
  property p_idle; WAKE_TO_IDLE_O |-> !$past(CHIP_SELECT_LOW_N_I, 3); endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");
  a_part: assert property (p_part) else $error("part code wrong");
  a_rev: assert property (p_rev) else $error("revision code wrong");
  a_offset: assert property (p_offset) else $error("offset estimate wrong");
  a_state: assert property (p_state) else $error("control state wrong");
  a_crc: assert property (p_crc) else $error("checksum low bits set");
  a_osc: assert property (p_osc) else $error("osc select enable wrong");
  a_wake: assert property (p_wake) else $error("wake value of cfg a wrong");
  a_idle: assert property (p_idle) else $error("wake to idle without select");
endmodule : radio_test_status_properties

bind radio_test_status_regs radio_test_status_properties #(
  .PART_CODE(PART_CODE), .REVISION_CODE(REVISION_CODE)) chk_u (.*);

// >>> testbench/radio_test_status_host.sv
// Wishbone host model issuing classic single cycles
module radio_test_status_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] q, output bit late);
    int n = 0;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 4'h1;
    dat_o <= 32'(d);
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 64);
    q = dat_i;
    late = (ack_i !== 1'b1);
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
  endtask : xfer
endmodule : radio_test_status_host

// >>> testbench/radio_test_status_regs_tb_top.sv
// Self-checking bench for the radio test and status register bank
`include "radio_test_status_map.svh"
module radio_test_status_regs_tb_top
  import radio_test_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] PART = 8'hA6;  // Arbitrary value
  localparam logic [7:0] REV  = 8'h4C;  // Arbitrary value
  localparam radio_status_t P_WAKE  = '{wake: 1'b1, default: '0};
  localparam radio_status_t P_MATCH = '{crc_done: 1'b1, crc_match: 1'b1, default: '0};
  localparam radio_status_t P_MISS  = '{crc_done: 1'b1, default: '0};
  localparam radio_status_t P_RX    = '{rx_enter: 1'b1, default: '0};
  logic          clk = 0, rstn = 0, chip_select_low = 1, cyc, stb, we, ack, irq, idle;
  logic [7:0]    adr;
  logic [3:0]    sel;
  logic [31:0]   wdat, rdat;
  radio_status_t st = '0;
  analog_cfg_t   acfg;
  int            errors = 0, samples_checked = 0;
  always #10 clk = ~clk;
  radio_test_status_host host_u (.clk_i(clk), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  radio_test_status_regs #(.PART_CODE(PART), .REVISION_CODE(REV)) dut_u (
    .CORE_CLK_I(clk), .RESETN_I(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .RADIO_STATUS_I(st), .CHIP_SELECT_LOW_N_I(chip_select_low), .WAKE_TO_IDLE_O(idle),
    .ANALOG_CFG_O(acfg), .IRQ_O(irq));
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask : chk
  task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d,
                     output logic [31:0] q);
    bit late;
    host_u.xfer(w, {i, 2'b00}, d, q, late);
    if (late) begin
      errors++;
      end_of_test();
    end
  endtask : bus
  task automatic rd(input string name, input logic [5:0] i, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, i, 8'h00, q);
    chk(name, exp, q);
  endtask : rd
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, i, d, q);
  endtask : wr
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // Raise event bits for one cycle, then let the flags settle
  task automatic pulse(input radio_status_t p);
    @(posedge clk);
    st <= st | p;
    @(posedge clk);
    st <= st & ~p;
    tick(2);
  endtask : pulse
  task automatic t_ro;
    st.offset_est <= 8'hF3;
    st.strength   <= 8'hA5;
    st.ctrl_state <= 5'h0D;
    for (int i = `IDX_PART; i <= `IDX_CTRL_STATE; i++) wr(6'(i), 8'hFF);
    rd("cfg_a", `IDX_CFG_A, `RST_CFG_A);
    rd("cfg_b", `IDX_CFG_B, `RST_CFG_B);
    rd("part", `IDX_PART, PART);
    rd("rev", `IDX_REVISION, REV);
    rd("offset", `IDX_OFFSET_EST, 32'h0000_00F3);
    rd("crc", `IDX_CHECKSUM, 32'h0000_0000);
    rd("strength", `IDX_STRENGTH, 32'h0000_00A5);
    rd("unmapped", 6'h3F, 32'h0000_0000);
    st.ook_mode <= 1'b1;
    rd("offset_ook", `IDX_OFFSET_EST, 32'h0000_0000);
    st.ook_mode <= 1'b0;
    $display("t_ro done");
  endtask : t_ro
  task automatic t_state;
    for (int v = 0; v <= 22; v++) begin
      st.ctrl_state <= 5'(v);
      rd("state", `IDX_CTRL_STATE, (v == 0 || v == 2) ? 32'h0000_0001 : 32'(v));
    end
    st.ctrl_state <= `ST_SLEEP;
    chip_select_low <= 1'b0;
    tick(5);
    chk("to_idle", 32'h0000_0001, 32'(idle));
    chip_select_low <= 1'b1;
    tick(5);
    chk("to_idle", 32'h0000_0000, 32'(idle));
    $display("t_state done");
  endtask : t_state
  task automatic t_wake;
    wr(`IDX_CFG_B, 8'h09);
    rd("cfg_b", `IDX_CFG_B, 32'h0000_0009);
    chk("osc_en", 32'h0000_0000, 32'(acfg.osc_select_cal_enable));
    wr(`IDX_CFG_A, 8'h3C);
    st.hold_select <= 1'b1;
    pulse(P_WAKE);
    chk("cfg_a_int", `WAKE_CFG_A_HOLD, 32'(acfg.cfg_a));
    rd("cfg_a", `IDX_CFG_A, `RST_CFG_A);
    st.hold_select <= 1'b0;
    wr(`IDX_CFG_A, 8'h3C);
    pulse(P_WAKE);
    chk("cfg_a_int", `RST_CFG_A, 32'(acfg.cfg_a));
    $display("t_wake done");
  endtask : t_wake
  task automatic t_crc;
    pulse(P_MATCH);
    rd("crc", `IDX_CHECKSUM, 32'h0000_0080);
    pulse(P_RX);
    rd("crc", `IDX_CHECKSUM, 32'h0000_0000);
    pulse(P_MATCH);
    pulse(P_MISS);
    rd("crc", `IDX_CHECKSUM, 32'h0000_0000);
    $display("t_crc done");
  endtask : t_crc
  // Every event has fired by now, masked, so all four flags are pending
  task automatic t_irq;
    rd("irq_status", `IDX_IRQ_STATUS, 32'h0000_000F);
    rd("irq_status", `IDX_IRQ_STATUS, 32'h0000_0000);
    wr(`IDX_IRQ_MASK, 8'h01);
    pulse(P_MATCH);
    chk("irq", 32'h0000_0001, 32'(irq));
    rd("irq_status", `IDX_IRQ_STATUS, 32'h0000_0001);
    tick(1);
    chk("irq", 32'h0000_0000, 32'(irq));
    pulse(P_WAKE);
    chk("irq", 32'h0000_0000, 32'(irq));
    rd("irq_status", `IDX_IRQ_STATUS, 32'h0000_0008);
    $display("t_irq done");
  endtask : t_irq
  initial begin
    tick(20);
    rstn <= 1'b1;
    tick(1);
    t_ro();
    t_state();
    t_wake();
    t_crc();
    t_irq();
    end_of_test();
  end
endmodule : radio_test_status_regs_tb_top
